//--- hw/mlls_cfg_if.sv
// monitor selector carried from the register slice to the monitor router
// assumes both ends share sys_clk_in
`timescale 1ns/1ps
interface mlls_cfg_if;
	logic [mlls_pkg::MON_SEL_W-1:0] mon_sel;

	modport regs  (output mon_sel);
	modport route (input  mon_sel);
endinterface : mlls_cfg_if

//--- hw/mlls_monitor_route.sv
// monitor router: places the selected rx or tx path onto channel zero's receive data
// assumes line inputs already synchronised to sys_clk_in
`timescale 1ns/1ps
module mlls_monitor_route #(
	parameter int NCH = mlls_pkg::NCH
) (
	// clock and reset
	input  wire logic           sys_clk_in,
	input  wire logic           rst_in,
	// selector
	mlls_cfg_if.route           cfg,
	// line data
	input  wire logic [NCH-1:0] rx_line_in,
	input  wire logic [NCH-1:0] tx_line_in,
	// routed result
	output logic                ch0_rx_data_out,
	output logic                mon_active_out
);

	logic [mlls_pkg::MON_CH_W-1:0] ch;
	logic                          pick_tx;
	logic                          enabled;
	logic                          route_next;
	logic                          ch0_reg;
	logic                          active_reg;

	assign ch      = cfg.mon_sel[mlls_pkg::MON_CH_W-1:0];
	assign pick_tx = cfg.mon_sel[mlls_pkg::MON_TX_BIT];
	assign enabled = (ch != mlls_pkg::MON_CH_OFF);   // [R1] [R2]

	// ---------------------------------------------------------------
	// path selection
	// ---------------------------------------------------------------
	always_comb begin
		route_next = rx_line_in[0];
		if (enabled && pick_tx) begin
			route_next = tx_line_in[ch];   // [R2]
		end else if (enabled) begin
			route_next = rx_line_in[ch];   // [R1]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ch0_reg <= 1'b0;
		end else begin
			ch0_reg <= route_next;   // [R10]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= enabled;
		end
	end

	assign ch0_rx_data_out = ch0_reg;
	assign mon_active_out  = active_reg;

	a_route_off_native: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R10]
		!enabled |=> ch0_rx_data_out == $past(rx_line_in[0]))
		else $error("channel zero not restored while monitoring is off");

	a_route_rx_pick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1]
		(enabled && !pick_tx) |=> ch0_rx_data_out == $past(rx_line_in[ch]))
		else $error("monitor did not carry the selected receive path");

	a_route_tx_pick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R2]
		(enabled && pick_tx) |=> ch0_rx_data_out == $past(tx_line_in[ch]))
		else $error("monitor did not carry the selected transmit path");

endmodule : mlls_monitor_route

//--- hw/mlls_pkg.sv
// shared constants of the monitor, loopback and loss-of-signal mode register slice
// assumes word-aligned register indices on a 32-bit classic Wishbone bus
package mlls_pkg;

	// ---------------------------------------------------------------
	// bus geometry
	// ---------------------------------------------------------------
	localparam int         ADR_W     = 8;
	localparam int         DAT_W     = 32;
	localparam int         SEL_W     = DAT_W / 8;
	localparam int         REG_W     = 8;
	localparam int         IDX_W     = 6;
	localparam int         IDX_LSB   = 2;
	localparam int         NCH       = 8;

	// ---------------------------------------------------------------
	// register indices, byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 6'h0A;
	localparam logic [IDX_W-1:0] IDX_MON_SEL    = 6'h0B;
	localparam logic [IDX_W-1:0] IDX_DLB        = 6'h0C;
	localparam logic [IDX_W-1:0] IDX_LOS_STD    = 6'h0D;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_SOFT_RESET = 8'h00;
	localparam logic [3:0]       RST_MON_SEL    = 4'h0;
	localparam logic [REG_W-1:0] RST_DLB        = 8'h00;
	localparam logic [REG_W-1:0] RST_LOS_STD    = 8'h00;

	// ---------------------------------------------------------------
	// monitor selector layout
	// ---------------------------------------------------------------
	localparam int         MON_SEL_W  = 4;
	localparam int         MON_TX_BIT = 3;
	localparam int         MON_CH_W   = 3;
	localparam logic [MON_CH_W-1:0] MON_CH_OFF = 3'h0;
	localparam logic [DAT_W-1:0]    RD_ZERO    = 32'h0000_0000;

endpackage : mlls_pkg

//--- hw/mlls_regs.sv
// register slice: monitor selector, digital loopback enables, loss-of-signal standards
// assumes a classic Wishbone master on sys_clk_in and asynchronous line and mode pins
//
// Functional notes
// R1: selector 0000 disables monitoring; 0001..0111 monitor receive path of channel 1..7.
// R2: selector 1000 disables monitoring; 1001..1111 monitor transmit path of channel 1..7.
// R3: after reset, selector, loopback enables and standard selections are all zero.
// R4: one bit per channel; one enables digital loopback, zero disables it.
// R5: in T1 or J1 mode, standard bits ignored; T1.231 criteria always applied.
// R6: in E1 mode, a one in bit n selects ETSI 300 233 for channel n.
// R7: in E1 mode, a zero in bit n selects ITU G.775 for channel n.
// R8: any write to the software reset register returns all registers to defaults.
// R9: software writes zero to the upper four reserved selector bits.
// R10: monitored path replaces channel zero receive data while monitoring is enabled.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module mlls_regs #(
	parameter int NCH = mlls_pkg::NCH
) (
	// clock and reset
	input  wire logic                        sys_clk_in,
	input  wire logic                        rst_in,
	// wishbone slave
	input  wire logic                        wb_cyc_in,
	input  wire logic                        wb_stb_in,
	input  wire logic                        wb_we_in,
	input  wire logic [mlls_pkg::ADR_W-1:0]  wb_adr_in,
	input  wire logic [mlls_pkg::SEL_W-1:0]  wb_sel_in,
	input  wire logic [mlls_pkg::DAT_W-1:0]  wb_dat_in,
	output logic [mlls_pkg::DAT_W-1:0]       wb_dat_out,
	output logic                             wb_ack_out,
	// line mode pin, high for E1
	input  wire logic                        e1_mode_in,
	// line data pins
	input  wire logic [NCH-1:0]              rx_line_in,
	input  wire logic [NCH-1:0]              tx_line_in,
	// channel controls
	output logic [NCH-1:0]                   dig_loopback_en_out,
	output logic [NCH-1:0]                   los_etsi_out,
	output logic [NCH-1:0]                   los_g775_out,
	output logic [NCH-1:0]                   los_t1231_out,
	// monitor result
	output logic                             ch0_rx_data_out,
	output logic                             mon_active_out
);

	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	generate
		if (NCH != mlls_pkg::REG_W) begin : g_bad_nch
			$error("channel count must equal the register width");
		end
	endgenerate

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic                              e1_meta_reg;
	logic                              e1_sync_reg;
	logic [NCH-1:0]                    rx_meta_reg;
	logic [NCH-1:0]                    rx_sync_reg;
	logic [NCH-1:0]                    tx_meta_reg;
	logic [NCH-1:0]                    tx_sync_reg;

	logic                              ack_reg;
	logic [mlls_pkg::DAT_W-1:0]        rdat_reg;
	logic [mlls_pkg::DAT_W-1:0]        rdat_next;
	logic [mlls_pkg::IDX_W-1:0]        idx;
	logic                              req;
	logic                              wr_fire;
	logic                              lane0;
	logic                              soft_wr;
	logic                              clr;

	logic [mlls_pkg::MON_SEL_W-1:0]    mon_sel_reg;
	logic [mlls_pkg::REG_W-1:0]        dlb_reg;
	logic [mlls_pkg::REG_W-1:0]        los_std_reg;
	logic [NCH-1:0]                    etsi_reg;
	logic [NCH-1:0]                    g775_reg;
	logic [NCH-1:0]                    t1231_reg;

	mlls_cfg_if cfg_bus ();

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			e1_meta_reg <= 1'b0;
			e1_sync_reg <= 1'b0;
		end else begin
			e1_meta_reg <= e1_mode_in;
			e1_sync_reg <= e1_meta_reg;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rx_meta_reg <= '0;
			rx_sync_reg <= '0;
			tx_meta_reg <= '0;
			tx_sync_reg <= '0;
		end else begin
			rx_meta_reg <= rx_line_in;
			rx_sync_reg <= rx_meta_reg;
			tx_meta_reg <= tx_line_in;
			tx_sync_reg <= tx_meta_reg;
		end
	end

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	assign idx     = wb_adr_in[mlls_pkg::ADR_W-1:mlls_pkg::IDX_LSB];
	assign req     = wb_cyc_in && wb_stb_in;
	assign lane0   = wb_sel_in[0];
	// writes land on the edge where the master sees ack
	assign wr_fire = req && wb_we_in && ack_reg;
	// any write, whatever the byte lanes, triggers the soft reset
	assign soft_wr = wr_fire && (idx == mlls_pkg::IDX_SOFT_RESET);   // [R8]
	assign clr     = rst_in || soft_wr;                                // [R3] [R8]

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	// ---------------------------------------------------------------
	// read mux, unmapped indices read zero
	// ---------------------------------------------------------------
	always_comb begin
		rdat_next = mlls_pkg::RD_ZERO;
		case (idx)
			mlls_pkg::IDX_SOFT_RESET: begin
				rdat_next[mlls_pkg::REG_W-1:0] = mlls_pkg::RST_SOFT_RESET;
			end
			mlls_pkg::IDX_MON_SEL: begin
				rdat_next[mlls_pkg::MON_SEL_W-1:0] = mon_sel_reg;
			end
			mlls_pkg::IDX_DLB: begin
				rdat_next[mlls_pkg::REG_W-1:0] = dlb_reg;
			end
			mlls_pkg::IDX_LOS_STD: begin
				rdat_next[mlls_pkg::REG_W-1:0] = los_std_reg;
			end
			default: begin
				rdat_next = mlls_pkg::RD_ZERO;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			rdat_reg <= mlls_pkg::RD_ZERO;
		end else if (req && !ack_reg && !wb_we_in) begin
			rdat_reg <= rdat_next;
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	// upper selector nibble is not stored, software keeps it zero [R9]
	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			mon_sel_reg <= mlls_pkg::RST_MON_SEL;   // [R3]
		end else if (wr_fire && lane0 && idx == mlls_pkg::IDX_MON_SEL) begin
			mon_sel_reg <= wb_dat_in[mlls_pkg::MON_SEL_W-1:0];   // [R1] [R2]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			dlb_reg <= mlls_pkg::RST_DLB;   // [R3]
		end else if (wr_fire && lane0 && idx == mlls_pkg::IDX_DLB) begin
			dlb_reg <= wb_dat_in[mlls_pkg::REG_W-1:0];   // [R4]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (clr) begin
			los_std_reg <= mlls_pkg::RST_LOS_STD;   // [R3]
		end else if (wr_fire && lane0 && idx == mlls_pkg::IDX_LOS_STD) begin
			los_std_reg <= wb_dat_in[mlls_pkg::REG_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// loss-of-signal criterion per channel
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			etsi_reg  <= '0;
			g775_reg  <= '0;
			t1231_reg <= '0;
		end else if (e1_sync_reg) begin
			etsi_reg  <= los_std_reg[NCH-1:0];    // [R6]
			g775_reg  <= ~los_std_reg[NCH-1:0];   // [R7]
			t1231_reg <= '0;
		end else begin
			etsi_reg  <= '0;                      // [R5]
			g775_reg  <= '0;
			t1231_reg <= '1;
		end
	end

	// ---------------------------------------------------------------
	// monitor routing
	// ---------------------------------------------------------------
	assign cfg_bus.mon_sel = mon_sel_reg;

	mlls_monitor_route #(
		.NCH (NCH)
	) u_route (
		.sys_clk_in      (sys_clk_in),
		.rst_in          (rst_in),
		.cfg             (cfg_bus.route),
		.rx_line_in      (rx_sync_reg),
		.tx_line_in      (tx_sync_reg),
		.ch0_rx_data_out (ch0_rx_data_out),
		.mon_active_out  (mon_active_out)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign wb_ack_out          = ack_reg;
	assign wb_dat_out          = rdat_reg;
	assign dig_loopback_en_out = dlb_reg[NCH-1:0];   // [R4]
	assign los_etsi_out        = etsi_reg;
	assign los_g775_out        = g775_reg;
	assign los_t1231_out       = t1231_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_ack_single_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");

	a_reset_clears_all: assert property (@(posedge sys_clk_in) // [R3]
		rst_in |=> (dlb_reg == mlls_pkg::RST_DLB && los_std_reg == mlls_pkg::RST_LOS_STD
			&& mon_sel_reg == mlls_pkg::RST_MON_SEL))
		else $error("registers not cleared by reset");

	a_loopback_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
		(wr_fire && lane0 && idx == mlls_pkg::IDX_DLB)
			|=> dig_loopback_en_out == $past(wb_dat_in[NCH-1:0]))
		else $error("loopback enables differ from written value");

	a_soft_reset_all: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
		soft_wr |=> (dlb_reg == mlls_pkg::RST_DLB && los_std_reg == mlls_pkg::RST_LOS_STD
			&& mon_sel_reg == mlls_pkg::RST_MON_SEL))
		else $error("soft reset left a register set");

	a_t1_mode_fixed: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R5]
		!e1_sync_reg |=> (los_t1231_out == '1 && los_etsi_out == '0 && los_g775_out == '0))
		else $error("T1 mode did not force T1.231 criteria");

	a_e1_etsi_pick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6]
		e1_sync_reg |=> (los_etsi_out == $past(los_std_reg) && los_t1231_out == '0))
		else $error("E1 ETSI selection does not follow register");

	a_e1_g775_pick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R7]
		e1_sync_reg |=> (los_g775_out == ~$past(los_std_reg)))
		else $error("E1 G.775 selection does not follow register");

	a_mon_sel_read: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1]
		(req && !ack_reg && !wb_we_in && idx == mlls_pkg::IDX_MON_SEL)
			|=> (wb_ack_out
				&& wb_dat_out == {{(mlls_pkg::DAT_W-mlls_pkg::MON_SEL_W){1'b0}}, mon_sel_reg}))
		else $error("selector readback wrong or late");

	a_ack_answer: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(req && !ack_reg) |=> wb_ack_out)
		else $error("request not answered in the next cycle");

	a_mon_sel_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1] [R2]
		(wr_fire && lane0 && idx == mlls_pkg::IDX_MON_SEL)
			|=> mon_sel_reg == $past(wb_dat_in[mlls_pkg::MON_SEL_W-1:0]))
		else $error("selector differs from written value");

	a_los_std_write: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6] [R7]
		(wr_fire && lane0 && idx == mlls_pkg::IDX_LOS_STD)
			|=> los_std_reg == $past(wb_dat_in[mlls_pkg::REG_W-1:0]))
		else $error("standard selection differs from written value");

	a_dlb_read: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
		(req && !ack_reg && !wb_we_in && idx == mlls_pkg::IDX_DLB)
			|=> wb_dat_out == {{(mlls_pkg::DAT_W-mlls_pkg::REG_W){1'b0}}, dlb_reg})
		else $error("loopback readback wrong");

	a_srst_read_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
		(req && !ack_reg && !wb_we_in && idx == mlls_pkg::IDX_SOFT_RESET)
			|=> wb_dat_out == mlls_pkg::RD_ZERO)
		else $error("software reset register did not read zero");

	a_mon_active_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R1] [R2]
		1'b1 |=> mon_active_out
			== ($past(mon_sel_reg[mlls_pkg::MON_CH_W-1:0]) != mlls_pkg::MON_CH_OFF))
		else $error("monitor active flag does not follow selector");

endmodule : mlls_regs

//--- tb/tb.sv
// self-checking bench for the monitor, loopback and loss-of-signal mode register slice
// assumes mlls_pkg compiled first and a 50 MHz clock with synchronous active-high reset
`timescale 1ns/1ps
module tb;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        sys_clk_in          = 1'b0;
	logic        rst_in              = 1'b1;
	logic        wb_cyc_in           = 1'b0;
	logic        wb_stb_in           = 1'b0;
	logic        wb_we_in            = 1'b0;
	logic [7:0]  wb_adr_in           = 8'h00;
	logic [3:0]  wb_sel_in           = 4'h0;
	logic [31:0] wb_dat_in           = 32'h0000_0000;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        e1_mode_in          = 1'b0;
	logic [7:0]  rx_line_in          = 8'h00;
	logic [7:0]  tx_line_in          = 8'h00;
	logic [7:0]  dig_loopback_en_out;
	logic [7:0]  los_etsi_out;
	logic [7:0]  los_g775_out;
	logic [7:0]  los_t1231_out;
	logic        ch0_rx_data_out;
	logic        mon_active_out;
	logic [15:0] lfsr_reg            = 16'h80A8;
	int          num_errors          = 0;
	int          checks              = 0;

	localparam logic [7:0] ADR_SRST = {mlls_pkg::IDX_SOFT_RESET, 2'b00};
	localparam logic [7:0] ADR_MON  = {mlls_pkg::IDX_MON_SEL, 2'b00};
	localparam logic [7:0] ADR_DLB  = {mlls_pkg::IDX_DLB, 2'b00};
	localparam logic [7:0] ADR_LOS  = {mlls_pkg::IDX_LOS_STD, 2'b00};

	always #10 sys_clk_in = ~sys_clk_in;

	mlls_regs #(.NCH(8)) mlls_regs_inst (
		.sys_clk_in          (sys_clk_in),
		.rst_in              (rst_in),
		.wb_cyc_in           (wb_cyc_in),
		.wb_stb_in           (wb_stb_in),
		.wb_we_in            (wb_we_in),
		.wb_adr_in           (wb_adr_in),
		.wb_sel_in           (wb_sel_in),
		.wb_dat_in           (wb_dat_in),
		.wb_dat_out          (wb_dat_out),
		.wb_ack_out          (wb_ack_out),
		.e1_mode_in          (e1_mode_in),
		.rx_line_in          (rx_line_in),
		.tx_line_in          (tx_line_in),
		.dig_loopback_en_out (dig_loopback_en_out),
		.los_etsi_out        (los_etsi_out),
		.los_g775_out        (los_g775_out),
		.los_t1231_out       (los_t1231_out),
		.ch0_rx_data_out     (ch0_rx_data_out),
		.mon_active_out      (mon_active_out)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] rnd();
		lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
		return lfsr_reg;
	endfunction : rnd

	function automatic logic exp_mon(input logic [3:0] c, input logic [7:0] rx,
			input logic [7:0] tx);
		if (c[2:0] == 3'h0) begin
			return rx[0];
		end
		return c[3] ? tx[c[2:0]] : rx[c[2:0]];
	endfunction : exp_mon

	task automatic report_and_stop();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check_eq

	// one classic cycle, held until ack is sampled high
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
			input logic [3:0] sel, output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= we;
		wb_adr_in <= adr;
		wb_sel_in <= sel;
		wb_dat_in <= wdat;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		if (wb_ack_out !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t no ack", $time);
			report_and_stop();
		end
		rdat = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in  <= 1'b0;
	endtask : wb_cycle

	task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		wb_cycle(1'b1, adr, d, sel, r);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] r;
		wb_cycle(1'b0, adr, 32'h0000_0000, 4'hF, r);
		check_eq(r, exp);
	endtask : rd_chk

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask : settle

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] rx;
		logic [7:0] tx;
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		settle(1);
		check_eq({24'h0, dig_loopback_en_out}, 32'h0000_0000);
		check_eq({31'h0, mon_active_out}, 32'h0000_0000);
		rd_chk(ADR_MON, 32'h0000_0000);
		rd_chk(ADR_DLB, 32'h0000_0000);
		rd_chk(ADR_LOS, 32'h0000_0000);
		// loopback enables, corners then random
		for (int i = 0; i < 10; i++) begin
			d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
			wr(ADR_DLB, {24'h0, d}, 4'hF);
			rd_chk(ADR_DLB, {24'h0, d});
			check_eq({24'h0, dig_loopback_en_out}, {24'h0, d});
		end
		// low byte disabled: write ignored
		wr(ADR_DLB, {24'h0, ~d}, 4'hE);
		rd_chk(ADR_DLB, {24'h0, d});
		// standard selection under both line modes
		for (int m = 0; m < 2; m++) begin
			@(posedge sys_clk_in);
			e1_mode_in <= m[0];
			settle(5);
			for (int i = 0; i < 6; i++) begin
				d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
				wr(ADR_LOS, {24'h0, d}, 4'hF);
				rd_chk(ADR_LOS, {24'h0, d});
				settle(2);
				check_eq({24'h0, los_t1231_out}, m ? 32'h0000_0000 : 32'h0000_00FF);
				check_eq({24'h0, los_etsi_out}, m ? {24'h0, d} : 32'h0000_0000);
				check_eq({24'h0, los_g775_out}, m ? {24'h0, ~d} : 32'h0000_0000);
			end
		end
		// every selector code, upper nibble kept zero
		for (int c = 0; c < 16; c++) begin
			wr(ADR_MON, {28'h0, c[3:0]}, 4'hF);
			rd_chk(ADR_MON, {28'h0, c[3:0]});
			for (int j = 0; j < 3; j++) begin
				{tx, rx} = rnd();
				@(posedge sys_clk_in);
				rx_line_in <= rx;
				tx_line_in <= tx;
				settle(4);
				check_eq({31'h0, mon_active_out}, {31'h0, c[2:0] != 3'h0});
				check_eq({31'h0, ch0_rx_data_out}, {31'h0, exp_mon(c[3:0], rx, tx)});
			end
		end
		// unmapped place reads zero, write has no effect
		wr(8'h3C, 32'h0000_00FF, 4'hF);
		rd_chk(8'h3C, 32'h0000_0000);
		rd_chk(ADR_MON, 32'h0000_000F);
		// software reset clears all three
		wr(ADR_DLB, 32'h0000_005A, 4'hF);
		wr(ADR_LOS, 32'h0000_00A5, 4'hF);
		wr(ADR_SRST, {16'h0000, rnd()}, 4'h0);
		rd_chk(ADR_MON, 32'h0000_0000);
		rd_chk(ADR_DLB, 32'h0000_0000);
		rd_chk(ADR_LOS, 32'h0000_0000);
		rd_chk(ADR_SRST, 32'h0000_0000);
		check_eq({31'h0, mon_active_out}, 32'h0000_0000);
		// hardware reset in mid-run
		wr(ADR_DLB, 32'h0000_00C3, 4'hF);
		wr(ADR_MON, 32'h0000_0009, 4'hF);
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_chk(ADR_DLB, 32'h0000_0000);
		rd_chk(ADR_MON, 32'h0000_0000);
		check_eq({24'h0, dig_loopback_en_out}, 32'h0000_0000);
		report_and_stop();
	end

endmodule : tb
